/* design/mtc_pkg.sv */
// Shared constants, codes and carriers for the machine trap return-address and cause registers.
// Assumes a single core clock domain; every user names items as mtc_pkg::name.
package mtc_pkg;

  // Machine register width and cause field layout
  localparam int XLEN = 64;
  localparam int CODE_W = 6;
  localparam int IRQ_BIT = XLEN - 1;
  localparam int PC_BIT0 = 0;
  localparam int PC_BIT1 = 1;

  // Set when instruction alignment may switch between 16 and 32; clear for 32-only parts
  localparam logic SUPPORT_ALIGN16 = 1'b1;

  // Reset values
  localparam logic [XLEN-1:0] RET_ADDR_RST = 64'h0;
  localparam logic [CODE_W-1:0] CODE_RST = 6'h00;

  // Interrupt cause codes; 16 and above belong to platform sources
  localparam logic [CODE_W-1:0] IRQ_S_SOFT = 6'h01;
  localparam logic [CODE_W-1:0] IRQ_M_SOFT = 6'h03;
  localparam logic [CODE_W-1:0] IRQ_S_TIMER = 6'h05;
  localparam logic [CODE_W-1:0] IRQ_M_TIMER = 6'h07;
  localparam logic [CODE_W-1:0] IRQ_S_EXT = 6'h09;
  localparam logic [CODE_W-1:0] IRQ_M_EXT = 6'h0b;
  localparam logic [CODE_W-1:0] IRQ_PLATFORM_BASE = 6'h10;

  // Exception codes
  localparam logic [CODE_W-1:0] EXC_INST_MISALIGN = 6'h00;
  localparam logic [CODE_W-1:0] EXC_INST_ACCESS = 6'h01;
  localparam logic [CODE_W-1:0] EXC_ILLEGAL = 6'h02;
  localparam logic [CODE_W-1:0] EXC_BREAKPOINT = 6'h03;
  localparam logic [CODE_W-1:0] EXC_LOAD_MISALIGN = 6'h04;
  localparam logic [CODE_W-1:0] EXC_LOAD_ACCESS = 6'h05;
  localparam logic [CODE_W-1:0] EXC_STORE_MISALIGN = 6'h06;
  localparam logic [CODE_W-1:0] EXC_STORE_ACCESS = 6'h07;
  localparam logic [CODE_W-1:0] EXC_ECALL_U = 6'h08;
  localparam logic [CODE_W-1:0] EXC_ECALL_S = 6'h09;
  localparam logic [CODE_W-1:0] EXC_ECALL_M = 6'h0b;
  localparam logic [CODE_W-1:0] EXC_INST_PAGE = 6'h0c;
  localparam logic [CODE_W-1:0] EXC_LOAD_PAGE = 6'h0d;
  localparam logic [CODE_W-1:0] EXC_STORE_PAGE = 6'h0f;

  // Privilege level of the instruction that raised an environment call
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;
  localparam logic [1:0] PRIV_M = 2'h3;

  // Register select on the control-register port
  typedef enum logic {SEL_RET_ADDR, SEL_CAUSE} mtc_sel_e;

  // Software access from the control-register port
  typedef struct packed {
    logic re;
    logic we;
    mtc_sel_e sel;
    logic [XLEN-1:0] wdata;
  } mtc_csr_req_s;

  // Synchronous exception flags raised by one instruction
  typedef struct packed {
    logic inst_bkpt;
    logic inst_page;
    logic inst_access;
    logic illegal;
    logic inst_misalign;
    logic ecall;
    logic breakpoint_instruction;
    logic data_bkpt;
    logic store_misalign;
    logic load_misalign;
    logic store_page;
    logic load_page;
    logic store_access;
    logic load_access;
    logic [1:0] priv;
  } mtc_exc_s;

  // Trap request from the pipeline
  typedef struct packed {
    logic valid;
    logic is_irq;
    logic [CODE_W-1:0] irq_code;
    logic [XLEN-1:0] pc;
  } mtc_trap_s;

endpackage

/* design/mtc_exc_prio.sv */
// Fixed-priority selector for the synchronous exceptions of one instruction.
// Purely combinational; the caller registers the result on trap entry.
module mtc_exc_prio (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire mtc_pkg::mtc_exc_s exc,
  output logic any,
  output logic [mtc_pkg::CODE_W-1:0] code
);

  // Environment call code follows the caller's privilege level
  function automatic logic [mtc_pkg::CODE_W-1:0] ecall_code(input logic [1:0] priv);
    case (priv)
      mtc_pkg::PRIV_U: ecall_code = mtc_pkg::EXC_ECALL_U;
      mtc_pkg::PRIV_S: ecall_code = mtc_pkg::EXC_ECALL_S;
      default: ecall_code = mtc_pkg::EXC_ECALL_M;
    endcase
  endfunction

  // Highest first; all three breakpoint kinds share one code but rank apart
  always_comb begin
    any = 1'b1;
    code = mtc_pkg::CODE_RST;
    if (exc.inst_bkpt) code = mtc_pkg::EXC_BREAKPOINT;
    else if (exc.inst_page) code = mtc_pkg::EXC_INST_PAGE;
    else if (exc.inst_access) code = mtc_pkg::EXC_INST_ACCESS;
    else if (exc.illegal) code = mtc_pkg::EXC_ILLEGAL;
    else if (exc.inst_misalign) code = mtc_pkg::EXC_INST_MISALIGN;
    else if (exc.ecall) code = ecall_code(exc.priv);
    else if (exc.breakpoint_instruction) code = mtc_pkg::EXC_BREAKPOINT;
    else if (exc.data_bkpt) code = mtc_pkg::EXC_BREAKPOINT;
    else if (exc.store_misalign) code = mtc_pkg::EXC_STORE_MISALIGN;
    else if (exc.load_misalign) code = mtc_pkg::EXC_LOAD_MISALIGN;
    else if (exc.store_page) code = mtc_pkg::EXC_STORE_PAGE;
    else if (exc.load_page) code = mtc_pkg::EXC_LOAD_PAGE;
    else if (exc.store_access) code = mtc_pkg::EXC_STORE_ACCESS;
    else if (exc.load_access) code = mtc_pkg::EXC_LOAD_ACCESS;
    else any = 1'b0;
  end

  property p_fetch_over_illegal;
    @(posedge sys_clk) disable iff (!nrst)
      exc.inst_access && exc.illegal && !exc.inst_bkpt && !exc.inst_page |-> code == mtc_pkg::EXC_INST_ACCESS;
  endproperty
  a_fetch_over_illegal: assert property (p_fetch_over_illegal) else $error("Illegal beat fetch fault");

  property p_misalign_last_fetch;
    @(posedge sys_clk) disable iff (!nrst)
      exc.inst_misalign && exc.load_access && !exc.inst_bkpt && !exc.inst_page && !exc.inst_access && !exc.illegal
      |-> code == mtc_pkg::EXC_INST_MISALIGN;
  endproperty
  a_misalign_last_fetch: assert property (p_misalign_last_fetch) else $error("Misaligned target rank wrong");

endmodule

/* design/mtc_trap_csr.sv */
// Machine trap return-address and cause registers with trap entry and trap-return read.
// Assumes the pipeline presents traps, software accesses and returns on sys_clk, one cycle each.
//
// Functional notes
// - Return address bit 0 always reads zero.
// - With 32-only alignment, bits 1 and 0 always zero.
// - Switchable alignment at 32 masks bit 1 on explicit reads.
// - Same bit-1 masking applies to the trap-return read.
// - Bit 1 still stores written values while masked.
// - Return address accepts any write and holds every valid virtual address.
// - Return address holds every physical address usable as pc.
// - Trap entry loads return address with the trapping instruction's address.
// - Hardware changes return address only on trap entry.
// - Trap entry loads cause with the event's code.
// - Hardware changes cause only on trap entry; software may write.
// - Cause top bit set for interrupts, clear for exceptions.
// - Exception code field only needs to hold supported codes.
// - Interrupt codes 1,3,5,7,9,11; others below 16 reserved.
// - Interrupt codes 16 and above belong to platform sources.
// - Exception codes for faults, misaligns, breakpoint and illegal as listed.
// - Environment call codes 8, 9, 11 by privilege; 10 reserved.
// - Custom exception ranges 24-31 and 48-63; other high codes reserved.
// - Several exceptions at once: only the highest priority is recorded.
// - Fixed exception priority order from breakpoint down to load access fault.
// - Instruction breakpoints share code 3 but rank separately.
// - Misaligned target exceptions rank below other instruction address exceptions.
// - Trap return loads pc from the return address register.
module mtc_trap_csr (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire mtc_pkg::mtc_csr_req_s csr_req,
  input wire mtc_pkg::mtc_trap_s trap_req,
  input wire mtc_pkg::mtc_exc_s exc,
  input wire logic instr_align_32,
  input wire logic ret_req,
  output logic [mtc_pkg::XLEN-1:0] csr_rdata,
  output logic csr_rvalid,
  output logic trap_ack,
  output logic [mtc_pkg::XLEN-1:0] ret_pc,
  output logic ret_valid
);

  // Stored state
  logic [mtc_pkg::XLEN-1:0] ret_addr;
  logic cause_irq;
  logic [mtc_pkg::CODE_W-1:0] cause_code;

  // Combinational decisions
  logic exc_any;
  logic [mtc_pkg::CODE_W-1:0] exc_code;
  logic trap_fire;
  logic sw_wr_ret;
  logic sw_wr_cause;
  logic [mtc_pkg::XLEN-1:0] next_ret_addr;
  logic next_cause_irq;
  logic [mtc_pkg::CODE_W-1:0] next_cause_code;

  // Exception selection lives in its own block
  mtc_exc_prio u_prio (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .exc(exc),
    .any(exc_any),
    .code(exc_code)
  );

  // Keep only what the register can legally hold when written
  function automatic logic [mtc_pkg::XLEN-1:0] legal_addr(input logic [mtc_pkg::XLEN-1:0] a);
    logic [mtc_pkg::XLEN-1:0] r;
    r = a;
    r[mtc_pkg::PC_BIT0] = 1'b0;
    if (!mtc_pkg::SUPPORT_ALIGN16) r[mtc_pkg::PC_BIT1] = 1'b0;
    legal_addr = r;
  endfunction

  // Read view; bit 1 is hidden at 32 alignment but left stored
  function automatic logic [mtc_pkg::XLEN-1:0] read_addr(input logic [mtc_pkg::XLEN-1:0] a, input logic al32);
    logic [mtc_pkg::XLEN-1:0] r;
    r = a;
    if (al32) r[mtc_pkg::PC_BIT1] = 1'b0;
    read_addr = r;
  endfunction

  // A trap with no cause is dropped rather than recording garbage
  assign trap_fire = trap_req.valid && (trap_req.is_irq || exc_any);
  assign sw_wr_ret = csr_req.we && csr_req.sel == mtc_pkg::SEL_RET_ADDR;
  assign sw_wr_cause = csr_req.we && csr_req.sel == mtc_pkg::SEL_CAUSE;

  // Next return address; trap entry wins over a software write in the same cycle
  always_comb begin
    next_ret_addr = ret_addr;
    if (trap_fire) next_ret_addr = legal_addr(trap_req.pc);
    else if (sw_wr_ret) next_ret_addr = legal_addr(csr_req.wdata);
  end

  // Next cause; interrupt code passes through, so platform codes need no table
  always_comb begin
    next_cause_irq = cause_irq;
    next_cause_code = cause_code;
    if (trap_fire) begin
      next_cause_irq = trap_req.is_irq;
      next_cause_code = trap_req.is_irq ? trap_req.irq_code : exc_code;
    end else if (sw_wr_cause) begin
      next_cause_irq = csr_req.wdata[mtc_pkg::IRQ_BIT];
      next_cause_code = csr_req.wdata[mtc_pkg::CODE_W-1:0];
    end
  end

  // Return address register, full width so every address fits
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ret_addr <= mtc_pkg::RET_ADDR_RST;
    end else begin
      ret_addr <= next_ret_addr;
    end
  end

  // Cause register, written in the same edge as the return address
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cause_irq <= 1'b0;
      cause_code <= mtc_pkg::CODE_RST;
    end else begin
      cause_irq <= next_cause_irq;
      cause_code <= next_cause_code;
    end
  end

  // Trap entry acknowledge, one cycle after the request
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      trap_ack <= 1'b0;
    end else begin
      trap_ack <= trap_fire;
    end
  end

  // Explicit read answer; shows the value stored before this cycle's write
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      csr_rdata <= mtc_pkg::RET_ADDR_RST;
      csr_rvalid <= 1'b0;
    end else begin
      csr_rvalid <= csr_req.re;
      if (csr_req.re) begin
        if (csr_req.sel == mtc_pkg::SEL_RET_ADDR) csr_rdata <= read_addr(ret_addr, instr_align_32);
        else csr_rdata <= {cause_irq, {(mtc_pkg::XLEN-1-mtc_pkg::CODE_W){1'b0}}, cause_code};
      end
    end
  end

  // Trap-return target; the pipeline loads pc from it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ret_pc <= mtc_pkg::RET_ADDR_RST;
      ret_valid <= 1'b0;
    end else begin
      ret_valid <= ret_req;
      if (ret_req) ret_pc <= read_addr(ret_addr, instr_align_32);
    end
  end

  property p_read_bit0;
    @(posedge sys_clk) disable iff (!nrst)
      csr_req.re && csr_req.sel == mtc_pkg::SEL_RET_ADDR |=> csr_rvalid && !csr_rdata[mtc_pkg::PC_BIT0];
  endproperty
  a_read_bit0: assert property (p_read_bit0) else $error("Return address bit 0 read as one");

  property p_read_mask32;
    @(posedge sys_clk) disable iff (!nrst)
      csr_req.re && csr_req.sel == mtc_pkg::SEL_RET_ADDR && instr_align_32 |=> !csr_rdata[mtc_pkg::PC_BIT1];
  endproperty
  a_read_mask32: assert property (p_read_mask32) else $error("Bit 1 visible at 32 alignment");

  property p_ret_mask;
    @(posedge sys_clk) disable iff (!nrst)
      ret_req && instr_align_32 |=> ret_valid && !ret_pc[mtc_pkg::PC_BIT1] && !ret_pc[mtc_pkg::PC_BIT0];
  endproperty
  a_ret_mask: assert property (p_ret_mask) else $error("Trap return target not masked");

  property p_bit1_kept;
    @(posedge sys_clk) disable iff (!nrst)
      sw_wr_ret && !trap_fire && instr_align_32 && mtc_pkg::SUPPORT_ALIGN16
      |=> ret_addr[mtc_pkg::PC_BIT1] == $past(csr_req.wdata[mtc_pkg::PC_BIT1]);
  endproperty
  a_bit1_kept: assert property (p_bit1_kept) else $error("Masked bit 1 lost its written value");

  property p_ret_follows_write;
    @(posedge sys_clk) disable iff (!nrst)
      ret_req && !instr_align_32 |=> ret_valid && ret_pc[mtc_pkg::XLEN-1:2] == $past(ret_addr[mtc_pkg::XLEN-1:2]);
  endproperty
  a_ret_follows_write: assert property (p_ret_follows_write) else $error("Trap return target differs");

  property p_trap_addr;
    @(posedge sys_clk) disable iff (!nrst)
      trap_fire |=> trap_ack && ret_addr[mtc_pkg::XLEN-1:2] == $past(trap_req.pc[mtc_pkg::XLEN-1:2]);
  endproperty
  a_trap_addr: assert property (p_trap_addr) else $error("Trap entry address not captured");

  property p_addr_quiet;
    @(posedge sys_clk) disable iff (!nrst)
      !trap_fire && !sw_wr_ret |=> $stable(ret_addr);
  endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("Return address changed without cause");

  property p_cause_kind;
    @(posedge sys_clk) disable iff (!nrst)
      trap_fire
      |=> cause_irq == $past(trap_req.is_irq);
  endproperty
  a_cause_kind: assert property (p_cause_kind) else $error("Interrupt flag wrong after trap");

  property p_cause_quiet;
    @(posedge sys_clk) disable iff (!nrst)
      !trap_fire && !sw_wr_cause |=> $stable(cause_code) && $stable(cause_irq);
  endproperty
  a_cause_quiet: assert property (p_cause_quiet) else $error("Cause changed without cause");

  property p_exc_code;
    @(posedge sys_clk) disable iff (!nrst)
      trap_fire && !trap_req.is_irq && exc.ecall && exc.priv == mtc_pkg::PRIV_S && !exc.inst_bkpt && !exc.inst_page
      && !exc.inst_access && !exc.illegal && !exc.inst_misalign |=> cause_code == mtc_pkg::EXC_ECALL_S && !cause_irq;
  endproperty
  a_exc_code: assert property (p_exc_code) else $error("Environment call code wrong");

  property p_irq_code;
    @(posedge sys_clk) disable iff (!nrst)
      trap_fire && trap_req.is_irq && exc.inst_page |=> cause_code == $past(trap_req.irq_code) && cause_irq;
  endproperty
  a_irq_code: assert property (p_irq_code) else $error("Interrupt code not recorded");

  property p_both_update;
    @(posedge sys_clk) disable iff (!nrst)
      trap_fire && (trap_req.pc[mtc_pkg::XLEN-1:2] != ret_addr[mtc_pkg::XLEN-1:2])
      |=> $changed(ret_addr) && trap_ack;
  endproperty
  a_both_update: assert property (p_both_update) else $error("Trap entry split across cycles");

  property p_single_code;
    @(posedge sys_clk) disable iff (!nrst)
      trap_fire && !trap_req.is_irq && exc.inst_bkpt && exc.load_access |=> cause_code == mtc_pkg::EXC_BREAKPOINT;
  endproperty
  a_single_code: assert property (p_single_code) else $error("Lower exception recorded");

  // Stored state, read views and entry pairing, checked every cycle
  property p_store_bit0;
    @(posedge sys_clk) disable iff (!nrst)
      !ret_addr[mtc_pkg::PC_BIT0];
  endproperty
  a_store_bit0: assert property (p_store_bit0) else $error("Stored bit 0 set");

  property p_write_lands;
    @(posedge sys_clk) disable iff (!nrst)
      sw_wr_ret && !trap_fire && mtc_pkg::SUPPORT_ALIGN16
      |=> ret_addr[mtc_pkg::XLEN-1:mtc_pkg::PC_BIT1] == $past(csr_req.wdata[mtc_pkg::XLEN-1:mtc_pkg::PC_BIT1]);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("Written address not held");

  property p_trap_full;
    @(posedge sys_clk) disable iff (!nrst)
      trap_fire && mtc_pkg::SUPPORT_ALIGN16
      |=> ret_addr[mtc_pkg::XLEN-1:mtc_pkg::PC_BIT1] == $past(trap_req.pc[mtc_pkg::XLEN-1:mtc_pkg::PC_BIT1]);
  endproperty
  a_trap_full: assert property (p_trap_full) else $error("Trap address truncated");

  property p_exc_cause;
    @(posedge sys_clk) disable iff (!nrst)
      trap_fire && !trap_req.is_irq |=> cause_code == $past(exc_code);
  endproperty
  a_exc_cause: assert property (p_exc_cause) else $error("Exception code not recorded");

  property p_platform_irq;
    @(posedge sys_clk) disable iff (!nrst)
      trap_fire && trap_req.is_irq && trap_req.irq_code >= mtc_pkg::IRQ_PLATFORM_BASE
      |=> cause_irq && cause_code == $past(trap_req.irq_code);
  endproperty
  a_platform_irq: assert property (p_platform_irq) else $error("Platform interrupt code lost");

  property p_sw_cause;
    @(posedge sys_clk) disable iff (!nrst)
      sw_wr_cause && !trap_fire |=> cause_code == $past(csr_req.wdata[mtc_pkg::CODE_W-1:0])
      && cause_irq == $past(csr_req.wdata[mtc_pkg::IRQ_BIT]);
  endproperty
  a_sw_cause: assert property (p_sw_cause) else $error("Cause write not held");

  property p_cause_read;
    @(posedge sys_clk) disable iff (!nrst)
      csr_req.re && csr_req.sel == mtc_pkg::SEL_CAUSE
      |=> csr_rdata[mtc_pkg::CODE_W-1:0] == $past(cause_code) && csr_rdata[mtc_pkg::IRQ_BIT] == $past(cause_irq);
  endproperty
  a_cause_read: assert property (p_cause_read) else $error("Cause read differs");

  property p_cause_pad;
    @(posedge sys_clk) disable iff (!nrst)
      csr_req.re && csr_req.sel == mtc_pkg::SEL_CAUSE |=> csr_rdata[mtc_pkg::IRQ_BIT-1:mtc_pkg::CODE_W] == '0;
  endproperty
  a_cause_pad: assert property (p_cause_pad) else $error("Cause middle bits set");

  property p_ret_hold;
    @(posedge sys_clk) disable iff (!nrst)
      !ret_req |=> $stable(ret_pc);
  endproperty
  a_ret_hold: assert property (p_ret_hold) else $error("Return target moved");

  property p_ack_quiet;
    @(posedge sys_clk) disable iff (!nrst)
      !trap_fire |=> !trap_ack;
  endproperty
  a_ack_quiet: assert property (p_ack_quiet) else $error("Acknowledge without trap");

  property p_illegal_code;
    @(posedge sys_clk) disable iff (!nrst)
      trap_fire && !trap_req.is_irq && exc.illegal && !exc.inst_bkpt && !exc.inst_page && !exc.inst_access
      |=> cause_code == mtc_pkg::EXC_ILLEGAL;
  endproperty
  a_illegal_code: assert property (p_illegal_code) else $error("Illegal code wrong");

  property p_data_bkpt;
    @(posedge sys_clk) disable iff (!nrst)
      trap_fire && !trap_req.is_irq && exc.data_bkpt && !exc.inst_bkpt && !exc.inst_page && !exc.inst_access
      && !exc.illegal && !exc.inst_misalign && !exc.ecall && !exc.breakpoint_instruction |=> cause_code == mtc_pkg::EXC_BREAKPOINT;
  endproperty
  a_data_bkpt: assert property (p_data_bkpt) else $error("Data breakpoint code wrong");

  property p_entry_pair;
    @(posedge sys_clk) disable iff (!nrst)
      trap_fire |=> trap_ack && cause_irq == $past(trap_req.is_irq)
      && ret_addr[mtc_pkg::XLEN-1:2] == $past(trap_req.pc[mtc_pkg::XLEN-1:2]);
  endproperty
  a_entry_pair: assert property (p_entry_pair) else $error("Entry registers not paired");

  property p_ret_pulse;
    @(posedge sys_clk) disable iff (!nrst)
      !ret_req |=> !ret_valid;
  endproperty
  a_ret_pulse: assert property (p_ret_pulse) else $error("Return valid without request");

  property p_ret_bit1;
    @(posedge sys_clk) disable iff (!nrst)
      ret_req && !instr_align_32 |=> ret_pc[mtc_pkg::PC_BIT1] == $past(ret_addr[mtc_pkg::PC_BIT1]);
  endproperty
  a_ret_bit1: assert property (p_ret_bit1) else $error("Bit 1 hidden at 16 alignment");

  property p_read_exact;
    @(posedge sys_clk) disable iff (!nrst)
      csr_req.re && csr_req.sel == mtc_pkg::SEL_RET_ADDR && !instr_align_32 |=> csr_rdata == $past(ret_addr);
  endproperty
  a_read_exact: assert property (p_read_exact) else $error("Return address read differs");

  property p_exc_flag;
    @(posedge sys_clk) disable iff (!nrst)
      trap_fire && !trap_req.is_irq |=> !cause_irq;
  endproperty
  a_exc_flag: assert property (p_exc_flag) else $error("Interrupt flag set on exception");

endmodule

/* dv/mtc_pipe_model.sv */
// Pipeline-side model: raises traps and trap-return requests.
// Assumes the bench calls its tasks just after a rising edge of sys_clk.
module mtc_pipe_model (
  input wire logic sys_clk,
  output mtc_pkg::mtc_trap_s trap_req,
  output mtc_pkg::mtc_exc_s exc,
  output logic ret_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet at time zero
  initial begin
    trap_req = '0;
    exc = '0;
    ret_req = 1'b0;
  end

  // One-cycle trap pulse; idle fields then carry inverted junk
  task automatic trap(input logic irq, input logic [5:0] code, input logic [63:0] pc,
                      input logic [13:0] flags, input logic [1:0] priv);
    @(posedge sys_clk);
    #1;
    trap_req = '{valid: 1'b1, is_irq: irq, irq_code: code, pc: pc};
    exc = {flags, priv};
    @(posedge sys_clk);
    #1;
    // Junk, not stale values, so unqualified sampling shows up
    trap_req = '{valid: 1'b0, is_irq: ~irq, irq_code: ~code, pc: ~pc};
    exc = ~{flags, priv};
  endtask

  // One-cycle trap-return request
  task automatic ret();
    @(posedge sys_clk);
    #1;
    ret_req = 1'b1;
    @(posedge sys_clk);
    #1;
    ret_req = 1'b0;
  endtask
endmodule

/* dv/tb_mtc_trap_csr.sv */
// Self-checking bench for the trap return-address and cause registers.
// Assumes the pipeline model drives trap and return; bench drives software access.
module tb_mtc_trap_csr;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk;
  logic nrst;
  logic instr_align_32;
  mtc_pkg::mtc_csr_req_s csr_req;
  mtc_pkg::mtc_trap_s trap_req;
  mtc_pkg::mtc_exc_s exc;
  logic ret_req;
  logic [63:0] csr_rdata;
  logic [63:0] ret_pc;
  logic csr_rvalid;
  logic trap_ack;
  logic ret_valid;
  int bad_count;
  int total_checks;
  logic [63:0] rd;
  // Expected code when flag i and all lower ones are raised together
  logic [5:0] prio_code [14] = '{6'h03, 6'h0c, 6'h01, 6'h02, 6'h00, 6'h08, 6'h03,
                                 6'h03, 6'h06, 6'h04, 6'h0f, 6'h0d, 6'h07, 6'h05};

  // 200 MHz core clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  mtc_trap_csr uut (.sys_clk(sys_clk), .nrst(nrst), .csr_req(csr_req), .trap_req(trap_req),
    .exc(exc), .instr_align_32(instr_align_32), .ret_req(ret_req), .csr_rdata(csr_rdata),
    .csr_rvalid(csr_rvalid), .trap_ack(trap_ack), .ret_pc(ret_pc), .ret_valid(ret_valid));

  mtc_pipe_model pipe (.sys_clk(sys_clk), .trap_req(trap_req), .exc(exc), .ret_req(ret_req));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Software read; data is taken one edge after the strobe
  task automatic csr_rd(input mtc_pkg::mtc_sel_e sel, output logic [63:0] data);
    @(posedge sys_clk);
    #1;
    csr_req = '{re: 1'b1, we: 1'b0, sel: sel, wdata: ~csr_req.wdata};
    @(posedge sys_clk);
    #1;
    csr_req.re = 1'b0;
    check({63'h0, csr_rvalid}, 64'h1);
    data = csr_rdata;
  endtask

  task automatic csr_wr(input mtc_pkg::mtc_sel_e sel, input logic [63:0] data);
    @(posedge sys_clk);
    #1;
    csr_req = '{re: 1'b0, we: 1'b1, sel: sel, wdata: data};
    @(posedge sys_clk);
    #1;
    csr_req.we = 1'b0;
  endtask

  task automatic do_ret(input logic [63:0] exp);
    pipe.ret();
    check({63'h0, ret_valid}, 64'h1);
    check(ret_pc, exp);
  endtask

  task automatic t_reset();
    csr_rd(mtc_pkg::SEL_RET_ADDR, rd);
    check(rd, 64'h0);
    csr_rd(mtc_pkg::SEL_CAUSE, rd);
    check(rd, 64'h0);
  endtask

  // Low-bit masking under both alignments, stored bit 1 survives
  task automatic t_ret_mask();
    csr_wr(mtc_pkg::SEL_RET_ADDR, 64'hffff_ffff_ffff_ffff);
    csr_rd(mtc_pkg::SEL_RET_ADDR, rd);
    check(rd, 64'hffff_ffff_ffff_fffe);
    instr_align_32 = 1'b1;
    csr_rd(mtc_pkg::SEL_RET_ADDR, rd);
    check(rd, 64'hffff_ffff_ffff_fffc);
    do_ret(64'hffff_ffff_ffff_fffc);
    csr_wr(mtc_pkg::SEL_RET_ADDR, 64'h0000_1111_2222_3337);
    csr_rd(mtc_pkg::SEL_RET_ADDR, rd);
    check(rd, 64'h0000_1111_2222_3334);
    instr_align_32 = 1'b0;
    csr_rd(mtc_pkg::SEL_RET_ADDR, rd);
    check(rd, 64'h0000_1111_2222_3336);
    csr_wr(mtc_pkg::SEL_RET_ADDR, 64'h8000_0000_1234_5676);
    csr_rd(mtc_pkg::SEL_RET_ADDR, rd);
    check(rd, 64'h8000_0000_1234_5676);
    do_ret(64'h8000_0000_1234_5676);
  endtask

  // Software cause write keeps only the flag and the code field
  task automatic t_cause_sw();
    csr_wr(mtc_pkg::SEL_CAUSE, 64'hffff_ffff_ffff_ffff);
    csr_rd(mtc_pkg::SEL_CAUSE, rd);
    check(rd, 64'h8000_0000_0000_003f);
    csr_wr(mtc_pkg::SEL_CAUSE, 64'h0000_0000_0000_0018);
    csr_rd(mtc_pkg::SEL_CAUSE, rd);
    check(rd, 64'h0000_0000_0000_0018);
  endtask

  // Flag i plus every lower flag at once: only flag i is reported
  task automatic t_prio();
    logic [63:0] pc;
    for (int i = 0; i < 14; i++) begin
      pc = 64'h0000_0040_0000_1001 + 64'(i * 6);
      pipe.trap(1'b0, 6'h2a, pc, 14'h3fff >> i, mtc_pkg::PRIV_U);
      check({63'h0, trap_ack}, 64'h1);
      csr_rd(mtc_pkg::SEL_CAUSE, rd);
      check(rd, {58'h0, prio_code[i]});
      csr_rd(mtc_pkg::SEL_RET_ADDR, rd);
      check(rd, pc & ~64'h1);
    end
  endtask

  // Environment call code follows the caller's privilege
  task automatic t_ecall();
    logic [1:0] pv [3] = '{mtc_pkg::PRIV_U, mtc_pkg::PRIV_S, mtc_pkg::PRIV_M};
    logic [5:0] cd [3] = '{6'h08, 6'h09, 6'h0b};
    for (int i = 0; i < 3; i++) begin
      pipe.trap(1'b0, 6'h00, 64'h2000, 14'h0100, pv[i]);
      csr_rd(mtc_pkg::SEL_CAUSE, rd);
      check(rd, {58'h0, cd[i]});
    end
  endtask

  // Interrupts set the top bit and pass the code; flags are ignored
  task automatic t_irq();
    logic [5:0] cd [7] = '{6'h01, 6'h03, 6'h05, 6'h07, 6'h09, 6'h0b, 6'h10};
    for (int i = 0; i < 7; i++) begin
      pipe.trap(1'b1, cd[i], 64'h3000 + 64'(i * 2), 14'h3fff, mtc_pkg::PRIV_M);
      check({63'h0, trap_ack}, 64'h1);
      csr_rd(mtc_pkg::SEL_CAUSE, rd);
      check(rd, {1'b1, 57'h0, cd[i]});
      csr_rd(mtc_pkg::SEL_RET_ADDR, rd);
      check(rd, 64'h3000 + 64'(i * 2));
    end
  endtask

  // Valid with no cause and a trap return must not touch either register
  task automatic t_no_trap();
    csr_wr(mtc_pkg::SEL_RET_ADDR, 64'h5554);
    csr_wr(mtc_pkg::SEL_CAUSE, 64'h2);
    pipe.trap(1'b0, 6'h07, 64'h9998, 14'h0000, mtc_pkg::PRIV_M);
    check({63'h0, trap_ack}, 64'h0);
    do_ret(64'h5554);
    csr_rd(mtc_pkg::SEL_RET_ADDR, rd);
    check(rd, 64'h5554);
    csr_rd(mtc_pkg::SEL_CAUSE, rd);
    check(rd, 64'h2);
  endtask

  task automatic finish_test();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence: reset for ten cycles, then every scenario
  initial begin
    bad_count = 0;
    total_checks = 0;
    nrst = 1'b0;
    instr_align_32 = 1'b0;
    csr_req = '0;
    repeat (10) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    t_reset();
    t_ret_mask();
    t_cause_sw();
    t_prio();
    t_ecall();
    t_irq();
    t_no_trap();
    finish_test();
  end

  // Watchdog; the run needs well under a thousand cycles
  initial begin
    #50000;
    bad_count++;
    finish_test();
  end
endmodule
